/* File: rtl/seha_top.sv */
// host register access to an external 16-bit serial eeprom
// Behaviour
// - Write status 1,0 means the low byte is held and the high byte is awaited.
// - Bytes go to write data low first; first clears status bit 0, second clears bit 1 and writes.
// - The pointer shows the word address and steps after each read pair or write pair.
// - After the second byte both low write status bits read zero while the word is written.
// - With write status bit 7 clear, a pointer write starts a prefetch.
// - With write status bit 7 set, a pointer write starts no prefetch.
// - Read data is invalid until read status bit 0 is set.
// - Each word is read as low byte then high byte.
// - After the high byte: clear valid, step pointer, fetch next word, set valid.
// - Read status bit 0 is high only while data is valid and clears on the high-byte data read.
// - Reading data while not valid does nothing harmful.
// - Read data sits at 0xf5 and read status at 0xf6, both read-only.
//
// Strobed register access was decided locally.
`default_nettype none
`include "seha_consts.svh"
module seha_top #(
  parameter int AW = 8,
  parameter int FIFO_DEPTH = `SEHA_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // eeprom pins
  output logic ee_cs_o,
  output logic ee_sk_o,
  output logic ee_di_o,
  input wire logic ee_do_i,
  // byte queue back-pressure
  output logic wbuf_ready_o
);
  import seha_pkg::*;

  logic [AW-1:0] ptr_q;
  logic [7:0] mode_q;
  logic nopf_q;
  logic [1:0] wstat_q;
  logic [7:0] lo_byte_q;
  logic hi_sel_q;
  logic rvalid_q;
  logic [15:0] rword_q;
  logic wr_busy_q;
  logic fetch_pend_q;
  logic step_after_q;
  logic ser_start;
  seha_op_t ser_op;
  logic ser_busy;
  logic ser_done;
  logic [15:0] ser_rdata;
  logic [15:0] ser_wdata;
  logic wr_data;
  logic rd_data;
  logic wr_ptr;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [7:0] fifo_out;
  logic fifo_in_ready;
  logic pair_ready;
  logic lo_pop;
  logic hi_pop;
  logic wr_fin;
  logic rd_step;
  logic fetch_go;
  logic rd_done;

  // register decode used by several processes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_data = reg_wr_i && hit(reg_addr_i, `SEHA_OFF_WDATA);
  assign rd_data = reg_rd_i && hit(reg_addr_i, `SEHA_OFF_RDATA);
  assign wr_ptr = reg_wr_i && hit(reg_addr_i, `SEHA_OFF_PTR);
  assign wbuf_ready_o = fifo_in_ready;

  // written bytes queue up; a byte written while the queue is full is dropped
  seha_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(wr_data),
    .in_ready_o(fifo_in_ready),
    .in_data_i(reg_wdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out),
    .flush_i(1'b0)
  );

  // both bytes wait for a free shifter; a low byte taken during a busy
  // write would let the status bits run ahead of the eeprom
  assign pair_ready = !wr_busy_q && !ser_busy && !fetch_pend_q;
  assign fifo_pop = fifo_out_valid && pair_ready;
  assign lo_pop = fifo_pop && !hi_sel_q;
  assign hi_pop = fifo_pop && hi_sel_q;
  assign wr_fin = wr_busy_q && ser_done;

  // write status bits; lo_pop and hi_pop exclude each other through hi_sel_q, and both exclude wr_fin through pair_ready
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wstat_q <= 2'(`SEHA_WSTAT_RST);
    end
    else if (lo_pop)
    begin
      wstat_q[0] <= 1'b0; // 1,0: waiting for high byte
    end
    else if (hi_pop)
    begin
      wstat_q[1] <= 1'b0; // 0,0 while busy writing
    end
    else if (wr_fin)
    begin
      wstat_q <= 2'b11; // ready for another pair
    end
  end

  // low byte held until its partner leaves the queue
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lo_byte_q <= 8'h00;
    end
    else if (lo_pop)
    begin
      lo_byte_q <= fifo_out; // low byte leads
    end
  end

  // which byte of the pair comes next
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hi_sel_q <= 1'b0;
    end
    else if (lo_pop)
    begin
      hi_sel_q <= 1'b1;
    end
    else if (hi_pop)
    begin
      hi_sel_q <= 1'b0;
    end
  end

  // busy from the high byte until the eeprom reports ready
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_busy_q <= 1'b0;
    end
    else if (hi_pop)
    begin
      wr_busy_q <= 1'b1; // second byte launches the write
    end
    else if (wr_fin)
    begin
      wr_busy_q <= 1'b0;
    end
  end

  // write data word for the shifter
  assign ser_wdata = {fifo_out, lo_byte_q};

  // shifter launch: a pending fetch holds back the byte queue, so reads go before waiting writes
  always_comb
  begin
    ser_start = 1'b0;
    ser_op = SEHA_OP_NONE;
    if (fifo_pop && hi_sel_q)
    begin
      ser_start = 1'b1;
      ser_op = SEHA_OP_WRITE; // second byte launches the write
    end
    else if (fetch_pend_q && !ser_busy && !wr_busy_q)
    begin
      ser_start = 1'b1;
      ser_op = SEHA_OP_READ;
    end
  end

  // read-side events
  assign fetch_go = ser_start && (ser_op == SEHA_OP_READ);
  assign rd_step = rd_data && rvalid_q && step_after_q;
  // a fetch overtaken by a pointer write with prefetch on is dropped, never shown
  assign rd_done = ser_done && !wr_busy_q && !fetch_go;

  // a fetch is owed until the shifter takes it
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fetch_pend_q <= 1'b0;
    end
    else if ((wr_ptr && !nopf_q) || rd_step)
    begin
      fetch_pend_q <= 1'b1; // prefetch, or next word after the step
    end
    else if (fetch_go)
    begin
      fetch_pend_q <= 1'b0;
    end
  end

  // read-valid flag: cleared first, set last once the word is in
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rvalid_q <= 1'b0;
    end
    else if ((wr_ptr && !nopf_q) || rd_step)
    begin
      rvalid_q <= 1'b0; // invalid until fetched
    end
    else if (rd_done)
    begin
      rvalid_q <= 1'b1; // set last, after fetch
    end
  end

  // fetched word
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rword_q <= 16'h0000;
    end
    else if (rd_done)
    begin
      rword_q <= ser_rdata;
    end
  end

  // low/high byte select for reads
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      step_after_q <= 1'b0;
    end
    else if (wr_ptr)
    begin
      step_after_q <= 1'b0;
    end
    else if (rd_data && rvalid_q)
    begin
      step_after_q <= ~step_after_q; // low then high
    end
  end

  // pointer: software load or step after each finished pair
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ptr_q <= AW'(`SEHA_PTR_RST);
    end
    else if (wr_ptr)
    begin
      ptr_q <= reg_wdata_i[AW-1:0];
    end
    else if ((rd_data && rvalid_q && step_after_q) || (wr_busy_q && ser_done))
    begin
      ptr_q <= ptr_q + 1'b1; // advance after read or write pair
    end
  end

  // mode bits and the prefetch disable bit; reserved bits not stored
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_q <= 8'h00;
      nopf_q <= 1'b0;
    end
    else
    begin
      if (reg_wr_i && hit(reg_addr_i, `SEHA_OFF_MODE))
      begin
        mode_q <= reg_wdata_i;
      end
      if (reg_wr_i && hit(reg_addr_i, `SEHA_OFF_WSTAT))
      begin
        nopf_q <= reg_wdata_i[`SEHA_BIT_NOPF]; // set blocks prefetch
      end
    end
  end

  seha_serial #(
    .AW(AW)
  ) u_serial (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(ser_start),
    .op_i(ser_op),
    .addr_i(ptr_q),
    .wdata_i(ser_wdata),
    .busy_o(ser_busy),
    .done_o(ser_done),
    .rdata_o(ser_rdata),
    .cs_o(ee_cs_o),
    .sk_o(ee_sk_o),
    .di_o(ee_di_o),
    .do_i(ee_do_i)
  );

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `SEHA_OFF_MODE: reg_rdata_o <= mode_q;
        `SEHA_OFF_PTR: reg_rdata_o <= 8'(ptr_q);
        `SEHA_OFF_WSTAT: reg_rdata_o <= {nopf_q, 5'h00, wstat_q};
        // stale byte on an invalid read, no side effect
        `SEHA_OFF_RDATA: reg_rdata_o <= step_after_q ? rword_q[15:8] : rword_q[7:0];
        `SEHA_OFF_RSTAT: reg_rdata_o <= {7'h00, rvalid_q};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
    else
    begin
      reg_rdata_o <= 8'h00;
    end
  end
endmodule : seha_top
`default_nettype wire

/* File: rtl/seha_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SEHA_CONSTS_SVH
`define SEHA_CONSTS_SVH
`define SEHA_OFF_MODE 8'hf1
`define SEHA_OFF_PTR 8'hf2
`define SEHA_OFF_WDATA 8'hf3
`define SEHA_OFF_WSTAT 8'hf4
`define SEHA_OFF_RDATA 8'hf5
`define SEHA_OFF_RSTAT 8'hf6
`define SEHA_WSTAT_RST 8'h03
`define SEHA_PTR_RST 8'h00
`define SEHA_BIT_NOPF 7
`define SEHA_BIT_RVALID 0
`define SEHA_CLK_NS 50
`define SEHA_SK_HALF_NS 500
`define SEHA_SK_HALF_CYC ((`SEHA_SK_HALF_NS + `SEHA_CLK_NS - 1) / `SEHA_CLK_NS)
`define SEHA_FIFO_DEPTH 16
`endif

/* File: rtl/seha_pkg.sv */
// types shared by the eeprom access block
`default_nettype none
package seha_pkg;
  typedef enum logic [1:0] {
    SEHA_OP_NONE = 2'b00,
    SEHA_OP_READ = 2'b01,
    SEHA_OP_WRITE = 2'b10
  } seha_op_t;
  typedef enum logic [2:0] {
    SEHA_ST_IDLE = 3'b000,
    SEHA_ST_START = 3'b001,
    SEHA_ST_SHIFT = 3'b010,
    SEHA_ST_WAIT = 3'b011,
    SEHA_ST_DONE = 3'b100
  } seha_state_t;
endpackage : seha_pkg
`default_nettype wire

/* File: rtl/seha_fifo.sv */
// parameterised valid/ready fifo
`default_nettype none
module seha_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // flush
  input wire logic flush_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest full and empty from the count
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage has no reset; only pointers and count need it
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (flush_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : seha_fifo
`default_nettype wire

/* File: rtl/seha_serial.sv */
// serial shifter toward the 16-bit eeprom (read or write one word)
`default_nettype none
`include "seha_consts.svh"
module seha_serial #(
  parameter int AW = 8,
  parameter int HALF = `SEHA_SK_HALF_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // request
  input wire logic start_i,
  input wire seha_pkg::seha_op_t op_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  // eeprom pins
  output logic cs_o,
  output logic sk_o,
  output logic di_o,
  input wire logic do_i
);
  import seha_pkg::*;
  localparam int FW = 3 + AW + 16;
  seha_state_t st_q;
  logic [FW-1:0] sh_q;
  logic [$clog2(FW+1)-1:0] bit_q;
  logic [$clog2(HALF+1)-1:0] div_q;
  logic is_wr_q;
  logic tick;

  assign tick = (div_q == '0);
  assign busy_o = (st_q != SEHA_ST_IDLE);

  // half-period divider for the serial clock
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_q <= '0;
    else if (st_q == SEHA_ST_IDLE || tick)
      div_q <= ($clog2(HALF+1))'(HALF - 1);
    else
      div_q <= div_q - 1'b1;
  end

  // frame sequencer: start bit, opcode, address, data; write waits for ready
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= SEHA_ST_IDLE;
      sh_q <= '0;
      bit_q <= '0;
      is_wr_q <= 1'b0;
      cs_o <= 1'b0;
      sk_o <= 1'b0;
      di_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
    end
    else
    begin
      done_o <= 1'b0;
      unique case (st_q)
        SEHA_ST_IDLE:
        begin
          if (start_i && op_i != SEHA_OP_NONE)
          begin
            is_wr_q <= (op_i == SEHA_OP_WRITE);
            sh_q <= {1'b1, (op_i == SEHA_OP_WRITE) ? 2'b01 : 2'b10, addr_i, wdata_i};
            bit_q <= ($clog2(FW+1))'(FW);
            cs_o <= 1'b1;
            st_q <= SEHA_ST_START;
          end
        end
        SEHA_ST_START:
        begin
          if (tick)
          begin
            di_o <= sh_q[FW-1];
            sh_q <= {sh_q[FW-2:0], 1'b0};
            st_q <= SEHA_ST_SHIFT;
          end
        end
        SEHA_ST_SHIFT:
        begin
          if (tick)
          begin
            sk_o <= ~sk_o;
            if (sk_o)
            begin
              bit_q <= bit_q - 1'b1;
              if (bit_q == ($clog2(FW+1))'(1))
              begin
                cs_o <= 1'b0;
                st_q <= is_wr_q ? SEHA_ST_WAIT : SEHA_ST_DONE;
              end
              else
              begin
                di_o <= sh_q[FW-1];
                sh_q <= {sh_q[FW-2:0], 1'b0};
              end
            end
            else if (!is_wr_q && bit_q <= ($clog2(FW+1))'(16))
            begin
              rdata_o <= {rdata_o[14:0], do_i}; // data shifted msb first
            end
          end
        end
        SEHA_ST_WAIT:
        begin
          // ready shows as do high with chip select raised again
          cs_o <= 1'b1;
          if (tick && cs_o && do_i)
          begin
            cs_o <= 1'b0;
            st_q <= SEHA_ST_DONE;
          end
        end
        SEHA_ST_DONE:
        begin
          done_o <= 1'b1;
          st_q <= SEHA_ST_IDLE;
        end
        default:
          st_q <= SEHA_ST_IDLE;
      endcase
    end
  end
endmodule : seha_serial
`default_nettype wire

/* File: dv/seha_sva.sv */
// assertion checker for the eeprom access block
`default_nettype none
module seha_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // pins
  input wire logic ee_cs_o,
  input wire logic wbuf_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic nopf_q;
  wire rd4 = reg_rd_i && reg_addr_i == 8'hf4;
  wire wr2 = reg_wr_i && reg_addr_i == 8'hf2 && !ee_cs_o;
  // shadow of the prefetch-off bit, so pointer writes can be judged
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      nopf_q <= 1'b0;
    else if (reg_wr_i && reg_addr_i == 8'hf4)
      nopf_q <= reg_wdata_i[7];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rdata_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_wstat_rsvd; rd4 |=> reg_rdata_o[6:2] == 5'h00; endproperty
  a_wstat_rsvd: assert property (p_wstat_rsvd) else $error("reserved bits set");
  property p_wstat_order; rd4 |=> reg_rdata_o[1:0] != 2'b01; endproperty
  a_wstat_order: assert property (p_wstat_order) else $error("bad byte order");
  property p_rstat_rsvd; reg_rd_i && reg_addr_i == 8'hf6 |=> reg_rdata_o[7:1] == 7'h00;
  endproperty
  a_rstat_rsvd: assert property (p_rstat_rsvd) else $error("read status high bits");
  property p_unmapped; reg_rd_i && reg_addr_i < 8'hf1 |=> reg_rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_prefetch; wr2 && !nopf_q |-> ##[1:8] ee_cs_o; endproperty
  a_prefetch: assert property (p_prefetch) else $error("no prefetch started");
  property p_no_prefetch; wr2 && nopf_q |=> !ee_cs_o [*4]; endproperty
  a_no_prefetch: assert property (p_no_prefetch) else $error("prefetch when off");
  property p_frame_len; $rose(ee_cs_o) |=> ee_cs_o [*8]; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame cut short");
  // main scenarios reached
  c_prefetch: cover property (wr2 && !nopf_q ##[1:8] ee_cs_o);
  c_busy: cover property (rd4 ##1 reg_rdata_o[1:0] == 2'b00);
  c_full: cover property (!wbuf_ready_o);
endmodule : seha_sva
bind seha_top seha_sva chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .ee_cs_o(ee_cs_o), .wbuf_ready_o(wbuf_ready_o));
`default_nettype wire

/* File: dv/seha_ee_model.sv */
// behavioural model of the 16-bit serial eeprom
`default_nettype none
module seha_ee_model #(
  parameter int AW = 8,
  parameter int BUSY_NS = 2000
) (
  // eeprom pins
  input wire logic cs_i,
  input wire logic sk_i,
  input wire logic di_i,
  output logic do_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:255];
  logic [31:0] sr;
  logic [15:0] word;
  logic busy;
  logic rd;
  int n;
  // word i holds ~i high and i low, so byte order shows
  initial
  begin
    busy = 1'b0;
    do_o = 1'b1;
    for (int i = 0; i < 256; i++)
      mem[i] = {~i[7:0], i[7:0]};
  end
  // selected: data line shows ready unless programming
  always @(posedge cs_i)
  begin
    n = 0;
    rd = 1'b0;
    do_o = !busy;
  end
  // shift in on the rising clock; fetch once the address is in
  always @(posedge sk_i)
    if (cs_i)
    begin
      sr = {sr[30:0], di_i};
      n++;
      if (n == AW + 3)
      begin
        rd = sr[AW+1:AW] == 2'b10;
        word = mem[sr[AW-1:0]];
      end
    end
  // read data msb first, changed on the falling clock
  always @(negedge sk_i)
    if (cs_i && rd)
    begin
      do_o = word[15];
      word = {word[14:0], 1'b0};
    end
  // a whole write frame programs; released line flips, never holds
  always @(negedge cs_i)
  begin
    if (n == AW + 19 && sr[AW+17:AW+16] == 2'b01)
    begin
      mem[sr[AW+15:16]] = sr[15:0];
      busy = 1'b1;
    end
    do_o = ~do_o;
  end
  // programming takes a fixed time
  always @(posedge busy)
  begin
    #(BUSY_NS);
    busy = 1'b0;
    if (cs_i)
      do_o = 1'b1;
  end
endmodule : seha_ee_model
`default_nettype wire

/* File: dv/seha_top_test.sv */
// self-checking bench for the eeprom access block
`default_nettype none
module seha_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, wbuf_ready_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic ee_cs_o, ee_sk_o, ee_di_o, ee_do_i;
  int fail_count = 0;
  int comparisons = 0;
  seha_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .ee_cs_o(ee_cs_o), .ee_sk_o(ee_sk_o),
    .ee_di_o(ee_di_o), .ee_do_i(ee_do_i), .wbuf_ready_o(wbuf_ready_o));
  seha_ee_model ee_u (.cs_i(ee_cs_o), .sk_i(ee_sk_o), .di_i(ee_di_o), .do_o(ee_do_i));
  // 50 ns bus clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : rd
  // bounded poll; a timeout shows up as a mismatch
  task automatic poll(input logic [7:0] a, m, e, input int n);
    for (int i = 0; i < n; i++)
    begin
      rd(a);
      if ((d & m) === e)
        break;
    end
    chk(d & m, e);
  endtask : poll
  task automatic t_reset();
    rd(8'hf4);
    chk(d, 8'h03);
    rd(8'hf2);
    chk(d, 8'h00);
    rd(8'hf6);
    chk(d, 8'h00);
  endtask : t_reset
  task automatic t_ro();
    wr(8'hf5, 8'hff);
    wr(8'hf6, 8'hff);
    rd(8'hf6);
    chk(d, 8'h00);
    rd(8'h10);
    chk(d, 8'h00);
  endtask : t_ro
  // early read while invalid must not disturb byte order
  task automatic t_read();
    wr(8'hf2, 8'h05);
    rd(8'hf6);
    chk(d, 8'h00);
    rd(8'hf5);
    poll(8'hf6, 8'h01, 8'h01, 500);
    rd(8'hf5);
    chk(d, 8'h05);
    rd(8'hf5);
    chk(d, 8'hfa);
    rd(8'hf6);
    chk(d, 8'h00);
    rd(8'hf2);
    chk(d, 8'h06);
    poll(8'hf6, 8'h01, 8'h01, 500);
    rd(8'hf5);
    chk(d, 8'h06);
    rd(8'hf5);
    chk(d, 8'hf9);
    poll(8'hf6, 8'h01, 8'h01, 500);
  endtask : t_read
  task automatic t_write();
    wr(8'hf4, 8'h80);
    wr(8'hf2, 8'h20);
    rd(8'hf6);
    chk(d, 8'h01);
    poll(8'hf4, 8'h03, 8'h03, 500);
    wr(8'hf3, 8'ha5);
    repeat (4) @(posedge clk_i);
    rd(8'hf4);
    chk(d, 8'h82);
    wr(8'hf3, 8'h3c);
    repeat (4) @(posedge clk_i);
    rd(8'hf4);
    chk(d, 8'h80);
    poll(8'hf4, 8'hff, 8'h83, 500);
    rd(8'hf2);
    chk(d, 8'h21);
    chk(ee_u.mem[8'h20], 16'h3ca5);
  endtask : t_write
  // queue fills while the eeprom is busy, then drains pair by pair
  task automatic t_fill();
    for (int i = 0; i < 18; i++)
      wr(8'hf3, i[7:0]);
    #1;
    chk(wbuf_ready_o, 1'b0);
    poll(8'hf2, 8'hff, 8'h2a, 4000);
    poll(8'hf4, 8'h03, 8'h03, 500);
    chk(wbuf_ready_o, 1'b1);
    chk(ee_u.mem[8'h29], 16'h1110);
  endtask : t_fill
  // reset, then the scenarios in turn
  initial
  begin
    rst_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_ro();
    t_read();
    t_write();
    t_fill();
    give_verdict();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #3000000;
    fail_count++;
    give_verdict();
  end
endmodule : seha_top_test
`default_nettype wire
